// ==== tpm_pkg.sv ====
package tpm_pkg;

  // ==========================================================
  // register map, byte addresses on the apb port
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_HTIME  = 8'h04;
  localparam logic [7:0] OFS_HSYNC  = 8'h08;
  localparam logic [7:0] OFS_VTIME  = 8'h0C;
  localparam logic [7:0] OFS_VSYNC  = 8'h10;
  localparam logic [7:0] OFS_PWM0   = 8'h14;
  localparam logic [7:0] OFS_PWM1   = 8'h18;
  localparam logic [7:0] OFS_PWM2   = 8'h1C;
  localparam logic [7:0] OFS_STATUS = 8'h20;

  // ==========================================================
  // field positions
  localparam int CTRL_MODE_LSB  = 0;
  localparam int CTRL_TIM_EN    = 2;
  localparam int CTRL_HS_POL    = 3;
  localparam int CTRL_VS_POL    = 4;
  localparam int CTRL_LOGIC_PWR = 8;
  localparam int CTRL_PANEL_EN  = 9;
  localparam int CTRL_BACKLIGHT = 10;
  localparam int PAIR_HI_LSB    = 16;
  localparam int PWM_SEL_LSB    = 8;
  localparam int PWM_EN_BIT     = 12;
  localparam int STAT_UNDERRUN  = 0;
  localparam int STAT_EMPTY     = 1;
  localparam int STAT_ACTIVE    = 2;

  // ==========================================================
  // reset values and limits
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [11:0] HACT_RST   = 12'h280;
  localparam logic [11:0] HTOT_RST   = 12'h320;
  localparam logic [11:0] VACT_RST   = 12'h1E0;
  localparam logic [11:0] VTOT_RST   = 12'h20D;
  localparam logic [11:0] HS_BEG_RST = 12'h290;
  localparam logic [11:0] HS_END_RST = 12'h2F0;
  localparam logic [11:0] VS_BEG_RST = 12'h1EA;
  localparam logic [11:0] VS_END_RST = 12'h1EC;
  localparam logic [11:0] MAX_HACT   = 12'd1920;
  localparam logic [11:0] MAX_VACT   = 12'd1440;

  // ==========================================================
  // pwm step prescales in sys_clk cycles, one per frequency choice
  localparam logic [7:0] PWM_DIV0 = 8'h01;
  localparam logic [7:0] PWM_DIV1 = 8'h04;
  localparam logic [7:0] PWM_DIV2 = 8'h10;

  localparam int FIFO_DEPTH = 32;

  typedef enum logic [1:0] {
    MODE_SINGLE18,
    MODE_SINGLE24,
    MODE_DOUBLE36,
    MODE_DUAL18
  } tpm_mode_e;

  typedef struct packed {
    logic [7:0] r_a;
    logic [7:0] g_a;
    logic [7:0] b_a;
    logic [5:0] r_b;
    logic [5:0] g_b;
    logic [5:0] b_b;
  } tpm_pix_s;

  typedef struct packed {
    logic       en;
    logic [1:0] sel;
    logic [7:0] duty;
  } tpm_pwm_s;

endpackage

// ==== tpm_fifo.sv ====
`timescale 1ns/1ps
module tpm_fifo #(
  parameter int W = 42,
  parameter int D = 32
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0]   count;
  logic          push;
  logic          load;

  // out_data is a register stage after the array: read data never
  // comes straight from the memory
  assign in_ready = (count != (AW+1)'(D));
  assign push     = in_valid & in_ready;
  assign load     = (count != '0) & (~out_valid | out_ready);

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + AW'(1);
      end
      if (load) begin
        rd_ptr <= rd_ptr + AW'(1);
      end
      count <= count + (AW+1)'(push) - (AW+1)'(load);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end else if (load) begin
      out_valid <= 1'b1;
      out_data  <= mem[rd_ptr];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end
endmodule

// ==== tpm_mapper.sv ====
// Notes on behaviour
// - single 18-bit puts 6-bit r,g,b on data bits 23:18, 15:10, 7:2.
// - single 24-bit puts 8-bit r,g,b on data bits 23:16, 15:8, 7:0.
// - double pixel puts first pixel on the single 18-bit pins.
// - double pixel puts second pixel low bits on 17:16, 9:8, 1:0.
// - double pixel puts second pixel upper bits on gpio 28:25, 15:12, 11:8.
// - first panel timing always leaves on the four dedicated timing pins.
// - dual mode drives first panel exactly as single 18-bit mode.
// - dual mode second panel syncs on analog pins, clock gpio16, de gpio29.
// - dual mode second panel colour bits use the same pins as second pixel.
// - exactly one of the panel arrangements is active at a time.
// - timing generation covers active areas up to 1920 by 1440.
// - logic power and panel enable change only on software writes.
// - backlight switch is a software-timed on/off output.
// - three pwm outputs, each with its own control register.
// - two pwm outputs offer three selectable frequencies each.
// - third pwm offers four frequency multiples locked to video sync.
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module tpm_mapper
  import tpm_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        pix_valid,
  output logic             pix_ready,
  input  wire tpm_pix_s    pix_data,
  input  wire logic        pix_clk_in,
  output logic [23:0]      panel_data_bus,
  output logic             panel_hsync_out,
  output logic             panel_vsync_out,
  output logic             panel_pixel_clock_out,
  output logic             panel_data_enable_out,
  output logic             analog_hsync_pin,
  output logic             analog_vsync_pin,
  output logic             analog_sync_oe,
  output logic [31:0]      gpio_panel_out,
  output logic [31:0]      gpio_panel_oe,
  output logic             panel_logic_power_ctl,
  output logic             panel_enable_ctl,
  output logic             backlight_ctl,
  output logic [2:0]       pwm_out
);

  // ==========================================================
  // reset release
  logic rst_meta_n;
  logic rst_sync_n;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // ==========================================================
  // registers
  logic [31:0] ctrl;
  logic [11:0] h_act;
  logic [11:0] h_tot;
  logic [11:0] v_act;
  logic [11:0] v_tot;
  logic [11:0] hs_beg;
  logic [11:0] hs_end;
  logic [11:0] vs_beg;
  logic [11:0] vs_end;
  tpm_pwm_s    pwm_cfg [3];
  logic        underrun;
  logic        wr_en;
  logic        rd_en;
  logic        hit;
  logic [31:0] next_prdata;
  tpm_mode_e   mode;

  // writes land at the edge where the master sees pready high
  assign wr_en = psel & penable & pwrite & pready;
  assign rd_en = psel & penable & ~pwrite & ~pready;
  assign mode  = tpm_mode_e'(ctrl[CTRL_MODE_LSB +: 2]);

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~hit;
      prdata  <= rd_en ? next_prdata : 32'h0000_0000;
    end
  end

  function automatic logic [11:0] clamp(input logic [11:0] v,
                                        input logic [11:0] lim);
    clamp = (v > lim) ? lim : v;
  endfunction

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ctrl   <= CTRL_RST;
      h_act  <= HACT_RST;
      h_tot  <= HTOT_RST;
      v_act  <= VACT_RST;
      v_tot  <= VTOT_RST;
      hs_beg <= HS_BEG_RST;
      hs_end <= HS_END_RST;
      vs_beg <= VS_BEG_RST;
      vs_end <= VS_END_RST;
    end else if (wr_en) begin
      unique case (paddr)
        OFS_CTRL: begin
          ctrl <= pwdata;
        end
        OFS_HTIME: begin
          h_act <= clamp(pwdata[11:0], MAX_HACT);
          h_tot <= pwdata[PAIR_HI_LSB +: 12];
        end
        OFS_HSYNC: begin
          hs_beg <= pwdata[11:0];
          hs_end <= pwdata[PAIR_HI_LSB +: 12];
        end
        OFS_VTIME: begin
          v_act <= clamp(pwdata[11:0], MAX_VACT);
          v_tot <= pwdata[PAIR_HI_LSB +: 12];
        end
        OFS_VSYNC: begin
          vs_beg <= pwdata[11:0];
          vs_end <= pwdata[PAIR_HI_LSB +: 12];
        end
        default: begin
        end
      endcase
    end
  end

  // each pwm has its own control word
  for (genvar k = 0; k < 3; k++) begin : g_pwm_reg
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        pwm_cfg[k] <= '0;
      end else if (wr_en && paddr == OFS_PWM0 + 8'(4 * k)) begin
        pwm_cfg[k].duty <= pwdata[7:0];
        pwm_cfg[k].sel  <= pwdata[PWM_SEL_LSB +: 2];
        pwm_cfg[k].en   <= pwdata[PWM_EN_BIT];
      end
    end
  end

  assign panel_logic_power_ctl = ctrl[CTRL_LOGIC_PWR];
  assign panel_enable_ctl      = ctrl[CTRL_PANEL_EN];
  assign backlight_ctl         = ctrl[CTRL_BACKLIGHT];

  // ==========================================================
  // pixel clock sampling
  logic clk_meta;
  logic clk_sync;
  logic clk_prev;
  logic pix_tick;

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      clk_meta <= 1'b0;
      clk_sync <= 1'b0;
      clk_prev <= 1'b0;
    end else begin
      clk_meta <= pix_clk_in;
      clk_sync <= clk_meta;
      clk_prev <= clk_sync;
    end
  end

  // data move on the falling edge so they are settled when the panel
  // samples on the rising edge of the mirrored clock
  assign pix_tick = clk_prev & ~clk_sync;

  // ==========================================================
  // pixel buffer
  logic     fifo_valid;
  logic     fifo_pop;
  tpm_pix_s fifo_data;

  tpm_fifo #(
    .W($bits(tpm_pix_s)),
    .D(FIFO_DEPTH)
  ) u_fifo (
    .clk      (sys_clk),
    .rst_n    (rst_sync_n),
    .in_valid (pix_valid),
    .in_ready (pix_ready),
    .in_data  (pix_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data (fifo_data)
  );

  // ==========================================================
  // timing generator
  logic [11:0] h_cnt;
  logic [11:0] v_cnt;
  logic        active;
  logic        hs_now;
  logic        vs_now;
  logic        line_start;
  logic        frame_start;

  assign active = ctrl[CTRL_TIM_EN] & (h_cnt < h_act) & (v_cnt < v_act);
  assign hs_now = (h_cnt >= hs_beg) & (h_cnt < hs_end);
  assign vs_now = (v_cnt >= vs_beg) & (v_cnt < vs_end);
  assign fifo_pop    = pix_tick & active & fifo_valid;
  assign line_start  = pix_tick & ctrl[CTRL_TIM_EN] & (h_cnt == 12'h000);
  assign frame_start = line_start & (v_cnt == 12'h000);

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      h_cnt <= 12'h000;
      v_cnt <= 12'h000;
    end else if (!ctrl[CTRL_TIM_EN]) begin
      h_cnt <= 12'h000;
      v_cnt <= 12'h000;
    end else if (pix_tick) begin
      if (h_cnt + 12'h001 >= h_tot) begin
        h_cnt <= 12'h000;
        v_cnt <= (v_cnt + 12'h001 >= v_tot) ? 12'h000 : v_cnt + 12'h001;
      end else begin
        h_cnt <= h_cnt + 12'h001;
      end
    end
  end

  // starved active pixel: blank colour, sticky flag, write 1 clears;
  // a new starve in the clearing cycle wins
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      underrun <= 1'b0;
    end else if (pix_tick && active && !fifo_valid) begin
      underrun <= 1'b1;
    end else if (wr_en && paddr == OFS_STATUS && pwdata[STAT_UNDERRUN]) begin
      underrun <= 1'b0;
    end
  end

  always_comb begin
    hit         = 1'b1;
    next_prdata = 32'h0000_0000;
    unique case (paddr)
      OFS_CTRL:   next_prdata = ctrl;
      OFS_HTIME:  next_prdata = {4'h0, h_tot, 4'h0, h_act};
      OFS_HSYNC:  next_prdata = {4'h0, hs_end, 4'h0, hs_beg};
      OFS_VTIME:  next_prdata = {4'h0, v_tot, 4'h0, v_act};
      OFS_VSYNC:  next_prdata = {4'h0, vs_end, 4'h0, vs_beg};
      OFS_PWM0:   next_prdata = {19'h0, pwm_cfg[0].en, 2'h0,
                                 pwm_cfg[0].sel, pwm_cfg[0].duty};
      OFS_PWM1:   next_prdata = {19'h0, pwm_cfg[1].en, 2'h0,
                                 pwm_cfg[1].sel, pwm_cfg[1].duty};
      OFS_PWM2:   next_prdata = {19'h0, pwm_cfg[2].en, 2'h0,
                                 pwm_cfg[2].sel, pwm_cfg[2].duty};
      OFS_STATUS: next_prdata = {29'h0, active, ~fifo_valid, underrun};
      default:    hit = 1'b0;
    endcase
  end

  // ==========================================================
  // pin mapping
  tpm_pix_s    px;
  logic [23:0] next_data;
  logic [31:0] next_gpio;
  logic [31:0] next_oe;
  logic        hs_out;
  logic        vs_out;

  assign px     = (active && fifo_valid) ? fifo_data : '0;
  assign hs_out = hs_now ^ ctrl[CTRL_HS_POL];
  assign vs_out = vs_now ^ ctrl[CTRL_VS_POL];

  always_comb begin
    next_data = 24'h000000;
    next_gpio = 32'h0000_0000;
    next_oe   = 32'h0000_0000;
    unique case (mode)
      MODE_SINGLE18: begin
        next_data[23:18] = px.r_a[7:2];
        next_data[15:10] = px.g_a[7:2];
        next_data[7:2]   = px.b_a[7:2];
      end
      MODE_SINGLE24: begin
        next_data = {px.r_a, px.g_a, px.b_a};
      end
      MODE_DOUBLE36, MODE_DUAL18: begin
        next_data[23:18] = px.r_a[7:2];
        next_data[15:10] = px.g_a[7:2];
        next_data[7:2]   = px.b_a[7:2];
        next_data[17:16] = px.r_b[1:0];
        next_data[9:8]   = px.g_b[1:0];
        next_data[1:0]   = px.b_b[1:0];
        next_gpio[28:25] = px.r_b[5:2];
        next_gpio[15:12] = px.g_b[5:2];
        next_gpio[11:8]  = px.b_b[5:2];
        next_oe[28:25]   = 4'hF;
        next_oe[15:8]    = 8'hFF;
        if (mode == MODE_DUAL18) begin
          next_gpio[29] = active;
          next_oe[29]   = 1'b1;
          next_oe[16]   = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      panel_data_bus        <= 24'h000000;
      panel_hsync_out       <= 1'b0;
      panel_vsync_out       <= 1'b0;
      panel_data_enable_out <= 1'b0;
      analog_hsync_pin      <= 1'b0;
      analog_vsync_pin      <= 1'b0;
      analog_sync_oe        <= 1'b0;
    end else if (pix_tick) begin
      panel_data_bus        <= next_data;
      panel_hsync_out       <= hs_out;
      panel_vsync_out       <= vs_out;
      panel_data_enable_out <= active;
      analog_hsync_pin      <= (mode == MODE_DUAL18) & hs_out;
      analog_vsync_pin      <= (mode == MODE_DUAL18) & vs_out;
      analog_sync_oe        <= (mode == MODE_DUAL18);
    end
  end

  // the mirrored clocks follow every sys_clk, the rest waits for a tick;
  // the second panel clock therefore shares the first panel's phase
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      panel_pixel_clock_out <= 1'b0;
      gpio_panel_out        <= 32'h0000_0000;
      gpio_panel_oe         <= 32'h0000_0000;
    end else begin
      panel_pixel_clock_out <= clk_sync;
      gpio_panel_out[16]    <= gpio_panel_oe[16] & clk_sync;
      if (pix_tick) begin
        gpio_panel_out[31:17] <= next_gpio[31:17];
        gpio_panel_out[15:0]  <= next_gpio[15:0];
        gpio_panel_oe         <= next_oe;
      end
    end
  end

  // ==========================================================
  // brightness pwm
  logic [7:0]  pre_cnt [2];
  logic [7:0]  duty_cnt [2];
  logic [2:0]  next_pwm;
  logic [11:0] p2_cnt;
  logic [11:0] p2_per;
  logic [19:0] p2_lim;

  for (genvar k = 0; k < 2; k++) begin : g_pwm
    logic [7:0] div;
    always_comb begin
      unique case (pwm_cfg[k].sel)
        2'h1:    div = PWM_DIV1;
        2'h2:    div = PWM_DIV2;
        default: div = PWM_DIV0;
      endcase
    end
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        pre_cnt[k]  <= 8'h00;
        duty_cnt[k] <= 8'h00;
      end else if (!pwm_cfg[k].en) begin
        pre_cnt[k]  <= 8'h00;
        duty_cnt[k] <= 8'h00;
      end else if (pre_cnt[k] + 8'h01 >= div) begin
        pre_cnt[k]  <= 8'h00;
        duty_cnt[k] <= duty_cnt[k] + 8'h01;
      end else begin
        pre_cnt[k] <= pre_cnt[k] + 8'h01;
      end
    end
    assign next_pwm[k] = pwm_cfg[k].en & (duty_cnt[k] < pwm_cfg[k].duty);
  end

  // third pwm counts lines; its period is one, a half, a quarter or an eighth frame
  assign p2_per = v_tot >> pwm_cfg[2].sel;
  assign p2_lim = 20'(pwm_cfg[2].duty) * 20'(p2_per);
  assign next_pwm[2] = pwm_cfg[2].en & ({p2_cnt, 8'h00} < p2_lim);

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      p2_cnt <= 12'h000;
    end else if (frame_start) begin
      p2_cnt <= 12'h000;
    end else if (line_start) begin
      p2_cnt <= (p2_cnt + 12'h001 >= p2_per) ? 12'h000 : p2_cnt + 12'h001;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pwm_out <= 3'h0;
    end else begin
      pwm_out <= next_pwm;
    end
  end

  // ==========================================================
  // checks
  a_low_bits_18: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    (pix_tick && mode == MODE_SINGLE18) |=>
    (panel_data_bus[17:16] == 2'h0 && panel_data_bus[1:0] == 2'h0))
    else $error("unused data bits not low in 18-bit mode");
  a_red_24: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    (fifo_pop && mode == MODE_SINGLE24) |=>
    (panel_data_bus[23:16] == $past(fifo_data.r_a)))
    else $error("24-bit red lane wrong");
  a_second_low: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    (fifo_pop && mode == MODE_DOUBLE36) |=>
    (panel_data_bus[9:8] == $past(fifo_data.g_b[1:0])))
    else $error("second pixel low green wrong");
  a_second_gpio: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    (fifo_pop && mode == MODE_DOUBLE36) |=>
    (gpio_panel_out[28:25] == $past(fifo_data.r_b[5:2])))
    else $error("second pixel red gpio wrong");
  a_dual_pins: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    (pix_tick && mode == MODE_DUAL18) |=>
    (gpio_panel_oe[16] && gpio_panel_oe[29] && analog_sync_oe))
    else $error("second panel pins not driven");
  a_gpio_free: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    (pix_tick && mode == MODE_SINGLE24) |=> (gpio_panel_oe == '0))
    else $error("gpio borrowed in single mode");
  a_size_limit: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    (h_act <= MAX_HACT && v_act <= MAX_VACT))
    else $error("active area above limit");
  a_power_sw: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    $changed(panel_logic_power_ctl) |->
    $past(wr_en && paddr == OFS_CTRL))
    else $error("panel power moved without write");
  a_pwm2_sync: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    frame_start |=> (p2_cnt == 12'h000))
    else $error("third pwm not restarted at frame");
  a_de_follow: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    pix_tick |=> (panel_data_enable_out == $past(active)))
    else $error("data enable out of step");
endmodule

// ==== tpm_panel_model.sv ====
`timescale 1ns/1ps
module tpm_panel_model (
  input  wire logic        pclk,
  input  wire logic        de,
  input  wire logic [23:0] data_a,
  input  wire logic [31:0] gpio,
  output logic [23:0]      cap_a,
  output logic [31:0]      cap_g
);
  // ========================================================
  // panel latch
  // samples on the rising clock, half a period after the
  // stage updates, so a late data change shows as a mismatch
  always @(posedge pclk) begin
    if (de === 1'b1) begin
      cap_a <= data_a;
      cap_g <= gpio;
    end
  end
endmodule

// ==== tft_panel_output_mapper_test.sv ====
`timescale 1ns/1ps
module tft_panel_output_mapper_test;
  import tpm_pkg::*;
  // ========================================================
  // signals
  logic        sys_clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic        pix_valid, pix_ready, pix_clk_in, se;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, gpio_panel_out, gpio_panel_oe, cap_g;
  logic [23:0] panel_data_bus, cap_a;
  logic        panel_hsync_out, panel_vsync_out, panel_pixel_clock_out;
  logic        panel_data_enable_out, analog_hsync_pin, analog_vsync_pin;
  logic        analog_sync_oe, panel_logic_power_ctl, panel_enable_ctl;
  logic        backlight_ctl;
  logic [2:0]  pwm_out;
  tpm_pix_s    pix_data;
  int          err_count, num_checks, acc, n, k, m, v, w;
  localparam tpm_pix_s PIX = '{8'hA5, 8'h3C, 8'hC3, 6'h2D, 6'h1E, 6'h33};
  localparam logic [31:0] OE [4] = '{32'h0, 32'h0, 32'h1E00_FF00,
                                     32'h3E01_FF00};

  tpm_mapper i_tpm_mapper (
    .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pix_valid(pix_valid),
    .pix_ready(pix_ready), .pix_data(pix_data), .pix_clk_in(pix_clk_in),
    .panel_data_bus(panel_data_bus), .panel_hsync_out(panel_hsync_out),
    .panel_vsync_out(panel_vsync_out),
    .panel_pixel_clock_out(panel_pixel_clock_out),
    .panel_data_enable_out(panel_data_enable_out),
    .analog_hsync_pin(analog_hsync_pin),
    .analog_vsync_pin(analog_vsync_pin), .analog_sync_oe(analog_sync_oe),
    .gpio_panel_out(gpio_panel_out), .gpio_panel_oe(gpio_panel_oe),
    .panel_logic_power_ctl(panel_logic_power_ctl),
    .panel_enable_ctl(panel_enable_ctl), .backlight_ctl(backlight_ctl),
    .pwm_out(pwm_out));

  tpm_panel_model i_tpm_panel_model (
    .pclk(panel_pixel_clock_out), .de(panel_data_enable_out),
    .data_a(panel_data_bus), .gpio(gpio_panel_out),
    .cap_a(cap_a), .cap_g(cap_g));

  // ========================================================
  // clocks; link clock phase unrelated to sys_clk
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial begin
    pix_clk_in = 1'b0;
    #7;
    forever #160 pix_clk_in = ~pix_clk_in;
  end
  always @(posedge sys_clk) begin
    if (pix_valid === 1'b1 && pix_ready === 1'b1) acc++;
  end

  // ========================================================
  // helpers
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [23:0] exp_bus(input int md, input tpm_pix_s p);
    if (md == 0) return {p.r_a[7:2], 2'h0, p.g_a[7:2], 2'h0,
                         p.b_a[7:2], 2'h0};
    if (md == 1) return {p.r_a, p.g_a, p.b_a};
    return {p.r_a[7:2], p.r_b[1:0], p.g_a[7:2], p.g_b[1:0],
            p.b_a[7:2], p.b_b[1:0]};
  endfunction

  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    #2000000;
    err_count++;
    stop_test;
  end

  // ========================================================
  // tests
  initial begin
    rst_n = 1'b0;
    {psel, penable, pwrite, pix_valid} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pix_data = PIX;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    apb(1'b0, OFS_HTIME, 32'h0);
    chk(rd, 32'h0320_0280);
    apb(1'b0, OFS_VSYNC, 32'h0);
    chk(rd, 32'h01EC_01EA);
    apb(1'b0, 8'h24, 32'h0);
    chk({31'h0, se}, 32'h1);
    apb(1'b1, OFS_HTIME, 32'h0320_0FFF);
    apb(1'b0, OFS_HTIME, 32'h0);
    chk(rd, 32'h0320_0780);
    // small raster: 4x2 active, 8x4 total
    apb(1'b1, OFS_HTIME, 32'h0008_0004);
    apb(1'b1, OFS_HSYNC, 32'h0006_0005);
    apb(1'b1, OFS_VTIME, 32'h0004_0002);
    apb(1'b1, OFS_VSYNC, 32'h0003_0002);
    $display("test registers done");
    // fill with timing off, then drain with the source stalled
    pix_valid <= 1'b1;
    for (n = 0; n < 200 && pix_ready !== 1'b0; n++) @(posedge sys_clk);
    repeat (5) @(posedge sys_clk);
    chk(acc, 33);
    pix_valid <= 1'b0;
    apb(1'b1, OFS_CTRL, 32'h0000_0004);
    repeat (2000) @(posedge sys_clk);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd & 32'h3, 32'h3);
    pix_valid <= 1'b1;
    repeat (100) @(posedge sys_clk);
    apb(1'b1, OFS_STATUS, 32'h1);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd & 32'h3, 32'h0);
    $display("test buffer done");
    for (m = 0; m < 4; m++) begin
      apb(1'b1, OFS_CTRL,
          32'h0000_0704 | m | ((m == 1) ? 32'h18 : 32'h0));
      @(negedge sys_clk);
      chk({panel_logic_power_ctl, panel_enable_ctl, backlight_ctl}, 7);
      repeat (600) @(posedge sys_clk);
      chk(cap_a, exp_bus(m, PIX));
      chk(gpio_panel_oe, OE[m]);
      chk(analog_sync_oe, m == 3);
      if (m >= 2) chk(cap_g & 32'h1E00_FF00, {3'h0, PIX.r_b[5:2], 9'h0,
          PIX.g_b[5:2], PIX.b_b[5:2], 8'h0});
      if (m == 3) chk(cap_g[29], 1);
      n = 0;
      k = 0;
      v = 0;
      w = 0;
      // one whole frame: 4 lines of 64 sys_clk cycles
      repeat (256) begin
        @(negedge sys_clk);
        n += panel_hsync_out;
        k += analog_hsync_pin;
        v += panel_vsync_out;
        w += analog_vsync_pin;
      end
      chk(n, (m == 1) ? 224 : 32);
      chk(k, (m == 3) ? 32 : 0);
      chk(v, (m == 1) ? 192 : 64);
      chk(w, (m == 3) ? 64 : 0);
    end
    $display("test modes done");
    for (m = 0; m < 2; m++) begin
      apb(1'b1, OFS_PWM0 + 8'(4 * m), 32'h0000_1040 | (m << 8));
      repeat (20) @(posedge sys_clk);
      n = 0;
      repeat (256 << (2 * m)) begin
        @(negedge sys_clk);
        n += pwm_out[m];
      end
      chk(n, 64 << (2 * m));
    end
    // third pwm: full-frame period, half duty, lines of 64 cycles
    apb(1'b1, OFS_PWM2, 32'h0000_1080);
    repeat (20) @(posedge sys_clk);
    n = 0;
    repeat (256) begin
      @(negedge sys_clk);
      n += pwm_out[2];
    end
    chk(n, 128);
    apb(1'b1, OFS_CTRL, 32'h0);
    @(negedge sys_clk);
    chk({panel_logic_power_ctl, panel_enable_ctl, backlight_ctl}, 0);
    $display("test pwm and power done");
    stop_test;
  end
endmodule
